// ### shared/rsmcp_defs.svh
/*
 File: constants for the serial control port (timing, characters, baud selection).
 Assumptions: included by its bare name from the design file that holds the port; the 200 MHz clock is the only clock.
*/
`ifndef RSMCP_DEFS_SVH
`define RSMCP_DEFS_SVH
`define RSMCP_CLK_HZ 200000000
`define RSMCP_BAUD_0 9600
`define RSMCP_BAUD_1 19200
`define RSMCP_BAUD_2 57600
`define RSMCP_BAUD_3 115200
`define RSMCP_DATA_BITS 8
`define RSMCP_CHAR_CR 8'h0D
`define RSMCP_CHAR_LF 8'h0A
`define RSMCP_BIT_LAST 3'h7
`define RSMCP_CTS_SLACK 5'h04
`define RSMCP_MIN_BIT_CLKS 8
`define RSMCP_MIN_FIFO_DEPTH 8
`endif

// ### shared/rsmcp_pkg.sv
/*
 File: types shared by the serial control port.
 Assumptions: compiled before the design files.
*/
package rsmcp_pkg;
   typedef enum logic [1:0] {RSMCP_B9600, RSMCP_B19200, RSMCP_B57600, RSMCP_B115200} rsmcp_baud_e;
   typedef enum {RSMCP_IDLE, RSMCP_START, RSMCP_DATA, RSMCP_STOP} rsmcp_state_e;
   typedef struct packed {
      logic [7:0] data;
      logic eol;
   } rsmcp_char_s;
endpackage : rsmcp_pkg

// ### logic/rsmcp_fifo.sv
/*
 File: holds no logic; the receive FIFO module rsmcp_fifo is kept in logic/rsmcp_port.sv with the rest of the port.
 Assumptions: nothing in this file is needed to build the design.
*/

// ### logic/rsmcp_port.sv
/*
 File: serial control port top: receiver, transmitter, modem-control gating and the receive FIFO.
 Assumptions: link pins are synchronous to the 200 MHz clock; modem lines are active high at these ports,
 an unconnected line reads as low; the command processor drains rx_* and feeds tx_*.
*/
`include "rsmcp_defs.svh"
module rsmcp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   // Pointers carry one extra bit, so full and empty differ without a separate flag.
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
      $error("rsmcp_fifo: DEPTH must be a power of two and WIDTH positive");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   wire logic do_wr = in_valid && in_ready;
   wire logic do_rd = out_valid && out_ready;
   assign level = wr_reg - rd_reg;
   assign in_ready = (level != (AW+1)'(DEPTH));
   assign out_valid = (wr_reg != rd_reg);
   assign out_data = mem[rd_reg[AW-1:0]];
   always_ff @(posedge clock) begin
      if (do_wr) mem[wr_reg[AW-1:0]] <= in_data;
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_reg + (AW+1)'(do_wr);
         rd_reg <= rd_reg + (AW+1)'(do_rd);
      end
   end
endmodule : rsmcp_fifo

module rsmcp_port #(
   parameter int FIFO_DEPTH = 32,
   parameter int CLK_HZ = `RSMCP_CLK_HZ
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic port_enable,
   input wire rsmcp_pkg::rsmcp_baud_e baud_sel,
   input wire logic rxd,
   output logic txd,
   input wire logic host_dtr,
   input wire logic host_rts,
   output logic dev_dsr,
   output logic dev_cts,
   output rsmcp_pkg::rsmcp_char_s rx_char,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic rx_dropped
);
   localparam int DIVW = 16;
   // The slowest rate must fit the bit counter and the fastest must leave a few clocks per bit.
   if (FIFO_DEPTH < `RSMCP_MIN_FIFO_DEPTH || CLK_HZ < `RSMCP_MIN_BIT_CLKS * `RSMCP_BAUD_3 ||
      CLK_HZ / `RSMCP_BAUD_0 >= (1 << DIVW)) begin : g_bad_param
      $error("rsmcp_port: FIFO_DEPTH or CLK_HZ out of range");
   end
   function automatic logic [DIVW-1:0] bit_cycles(input rsmcp_pkg::rsmcp_baud_e sel);
      case (sel)
         rsmcp_pkg::RSMCP_B9600: bit_cycles = DIVW'(CLK_HZ / `RSMCP_BAUD_0);
         rsmcp_pkg::RSMCP_B19200: bit_cycles = DIVW'(CLK_HZ / `RSMCP_BAUD_1);
         rsmcp_pkg::RSMCP_B57600: bit_cycles = DIVW'(CLK_HZ / `RSMCP_BAUD_2);
         default: bit_cycles = DIVW'(CLK_HZ / `RSMCP_BAUD_3);
      endcase
   endfunction : bit_cycles
   wire logic [DIVW-1:0] bit_len = bit_cycles(baud_sel);
   wire logic [DIVW-1:0] half_len = bit_len >> 1;
   // Host present and port enabled: only then is received data accepted.
   wire logic link_up = port_enable && host_dtr;
   // Receiver.
   rsmcp_pkg::rsmcp_state_e rs_reg;
   logic [DIVW-1:0] rcnt_reg;
   logic [2:0] rbit_reg;
   logic [7:0] rsh_reg;
   logic rpush_reg;
   logic rxd_reg;
   logic rdrop_reg;
   wire logic rtick = (rcnt_reg == '0);
   wire rsmcp_pkg::rsmcp_char_s push_char = '{data: rsh_reg, eol: (rsh_reg == `RSMCP_CHAR_CR) ||
      (rsh_reg == `RSMCP_CHAR_LF)};
   wire logic fifo_in_ready;
   wire logic [$clog2(FIFO_DEPTH):0] fifo_level;
   wire logic stop_ok = rtick && rxd_reg;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rs_reg <= rsmcp_pkg::RSMCP_IDLE;
         rcnt_reg <= '0;
         rbit_reg <= '0;
         rsh_reg <= '0;
         rpush_reg <= 1'b0;
         rxd_reg <= 1'b1;
         rdrop_reg <= 1'b0;
      end else begin
         rxd_reg <= rxd;
         rpush_reg <= 1'b0;
         rdrop_reg <= 1'b0;
         rcnt_reg <= rtick ? '0 : rcnt_reg - 1'b1;
         case (rs_reg)
            rsmcp_pkg::RSMCP_IDLE: if (!rxd_reg) begin
               rs_reg <= rsmcp_pkg::RSMCP_START;
               rcnt_reg <= half_len;
            end
            rsmcp_pkg::RSMCP_START: if (rtick) begin
               rs_reg <= rxd_reg ? rsmcp_pkg::RSMCP_IDLE : rsmcp_pkg::RSMCP_DATA;
               // Reloading one less than the bit length makes each sample exactly one bit apart.
               rcnt_reg <= bit_len - 1'b1;
               rbit_reg <= '0;
            end
            rsmcp_pkg::RSMCP_DATA: if (rtick) begin
               rsh_reg <= {rxd_reg, rsh_reg[7:1]};
               rcnt_reg <= bit_len - 1'b1;
               rbit_reg <= rbit_reg + 1'b1;
               if (rbit_reg == `RSMCP_BIT_LAST) rs_reg <= rsmcp_pkg::RSMCP_STOP;
            end
            rsmcp_pkg::RSMCP_STOP: if (rtick) begin
               rs_reg <= rsmcp_pkg::RSMCP_IDLE;
               // Without a host present the character is noise and never queued.
               rpush_reg <= stop_ok && link_up && fifo_in_ready;
               rdrop_reg <= stop_ok && link_up && !fifo_in_ready;
            end
            default: rs_reg <= rsmcp_pkg::RSMCP_IDLE;
         endcase
      end
   end
   wire rsmcp_pkg::rsmcp_char_s fifo_out;
   wire logic fifo_valid;
   // The output register refills whenever it is empty or being taken, so it never stalls the queue.
   wire logic fifo_pop = fifo_valid && (!rx_valid || rx_ready);
   rsmcp_fifo #(.WIDTH($bits(rsmcp_pkg::rsmcp_char_s)), .DEPTH(FIFO_DEPTH)) u_rxq (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(push_char),
      .in_valid(rpush_reg),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .level(fifo_level)
   );
   // Registered head of queue: outputs come from flops, at the cost of one extra word of storage.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_char <= '0;
      end else if (fifo_pop) begin
         rx_valid <= 1'b1;
         rx_char <= fifo_out;
      end else if (rx_ready) begin
         rx_valid <= 1'b0;
      end
   end
   // Clear-to-send drops with room for a few characters, since the host may finish one already begun.
   wire logic room = fifo_level < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - `RSMCP_CTS_SLACK);
   // Transmitter.
   rsmcp_pkg::rsmcp_state_e ts_reg;
   logic [DIVW-1:0] tcnt_reg;
   logic [2:0] tbit_reg;
   logic [7:0] tsh_reg;
   wire logic ttick = (tcnt_reg == '0);
   wire logic tx_take = (ts_reg == rsmcp_pkg::RSMCP_IDLE) && tx_valid && tx_ready;
   // Ready is registered, so a drop of request-to-send stops new characters one clock later.
   wire logic tx_idle_next = ((ts_reg == rsmcp_pkg::RSMCP_IDLE) && !tx_take) ||
      ((ts_reg == rsmcp_pkg::RSMCP_STOP) && ttick);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ts_reg <= rsmcp_pkg::RSMCP_IDLE;
         tcnt_reg <= '0;
         tbit_reg <= '0;
         tsh_reg <= '0;
         txd <= 1'b1;
         dev_dsr <= 1'b0;
         dev_cts <= 1'b0;
         rx_dropped <= 1'b0;
         tx_ready <= 1'b0;
      end else begin
         dev_dsr <= port_enable;
         dev_cts <= link_up && room;
         rx_dropped <= rdrop_reg;
         tx_ready <= tx_idle_next && host_rts && port_enable;
         tcnt_reg <= ttick ? '0 : tcnt_reg - 1'b1;
         case (ts_reg)
            rsmcp_pkg::RSMCP_IDLE: if (tx_take) begin
               ts_reg <= rsmcp_pkg::RSMCP_START;
               tsh_reg <= tx_data;
               tcnt_reg <= bit_len - 1'b1;
               txd <= 1'b0;
            end
            rsmcp_pkg::RSMCP_START: if (ttick) begin
               ts_reg <= rsmcp_pkg::RSMCP_DATA;
               tcnt_reg <= bit_len - 1'b1;
               tbit_reg <= '0;
               txd <= tsh_reg[0];
               tsh_reg <= tsh_reg >> 1;
            end
            rsmcp_pkg::RSMCP_DATA: if (ttick) begin
               tcnt_reg <= bit_len - 1'b1;
               tbit_reg <= tbit_reg + 1'b1;
               if (tbit_reg == `RSMCP_BIT_LAST) begin
                  ts_reg <= rsmcp_pkg::RSMCP_STOP;
                  txd <= 1'b1;
               end else begin
                  txd <= tsh_reg[0];
                  tsh_reg <= tsh_reg >> 1;
               end
            end
            rsmcp_pkg::RSMCP_STOP: if (ttick) ts_reg <= rsmcp_pkg::RSMCP_IDLE;
            default: ts_reg <= rsmcp_pkg::RSMCP_IDLE;
         endcase
      end
   end
endmodule : rsmcp_port

// ### tb/rsmcp_checker.sv
/* Concurrent checks on the serial control port pins.
   Assumes the single clock and synchronous active-low reset of rsmcp_port. */
module rsmcp_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic port_enable,
   input wire logic txd,
   input wire logic host_dtr,
   input wire logic host_rts,
   input wire logic dev_dsr,
   input wire logic dev_cts,
   input wire rsmcp_pkg::rsmcp_char_s rx_char,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic rx_dropped
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence start_bit;
      !txd [*8];
   endsequence
   dsr_follows_a: assert property ($past(rst_n) |-> dev_dsr == $past(port_enable)) else $error("dsr wrong");
   cts_gated_a: assert property (
      $past(rst_n) && !($past(host_dtr) && $past(port_enable)) |-> !dev_cts) else $error("cts without host");
   tx_gated_a: assert property (
      tx_ready |-> $past(host_rts) && $past(port_enable)) else $error("tx ready without request-to-send");
   tx_idle_a: assert property (tx_ready |-> txd) else $error("txd not idle");
   start_len_a: assert property (tx_valid && tx_ready |=> start_bit) else $error("start bit short");
   eol_flag_a: assert property (
      rx_valid |-> rx_char.eol == (rx_char.data inside {8'h0D, 8'h0A})) else $error("eol flag wrong");
   rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_char)) else $error("rx lost");
   no_dtr_a: assert property (!host_dtr [*8] |-> !$rose(rx_valid)) else $error("noise accepted");
   drop_full_a: assert property (rx_dropped |-> rx_valid && !dev_cts) else $error("bad drop");
endmodule : rsmcp_checker
bind rsmcp_port rsmcp_checker chk (.clock, .rst_n, .port_enable, .txd, .host_dtr, .host_rts, .dev_dsr, .dev_cts,
   .rx_char, .rx_valid, .rx_ready, .tx_valid, .tx_ready, .rx_dropped);

// ### tb/rsmcp_host.sv
/* Host serial port model: sends frames on rxd, collects frames from txd.
   Assumes bl holds clocks per bit, set by the bench to match baud_sel. */
module rsmcp_host (
   input wire logic clock,
   input wire logic txd,
   input wire logic dev_cts,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   int bl = 10;
   logic [7:0] got[$];
   initial rxd = 1'b1;
   // With wt low the clear-to-send line is ignored, as a misbehaving host would.
   task automatic send(input logic [7:0] b, input bit wt);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (wt && dev_cts !== 1'b1) @(negedge clock);
      for (int i = 0; i < 10; i++) begin
         rxd = f[i];
         repeat (bl) @(negedge clock);
      end
   endtask : send
   always @(negedge txd) begin : rx_mon
      logic [7:0] b;
      repeat (bl / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (bl) @(posedge clock);
         b[i] = txd;
      end
      repeat (bl) @(posedge clock);
      if (txd === 1'b1) got.push_back(b);
   end
endmodule : rsmcp_host

// ### tb/rsmcp_port_tb.sv
/* Bench for rsmcp_port: modem gating, both directions at all rates, FIFO fill and drain.
   Assumes a reduced CLK_HZ so that one bit is a few clocks long. */
module rsmcp_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HZ = 1152000;
   logic clock = 1'b0, rst_n = 1'b0, port_enable = 1'b0, host_dtr = 1'b0, host_rts = 1'b0, rx_ready = 1'b0;
   logic tx_valid = 1'b0, rxd, txd, dev_dsr, dev_cts, rx_valid, tx_ready, rx_dropped;
   logic [7:0] tx_data = 8'h00;
   logic loop_cable = 1'b0;
   rsmcp_pkg::rsmcp_baud_e baud_sel = rsmcp_pkg::RSMCP_B115200;
   rsmcp_pkg::rsmcp_char_s rx_char;
   int n_errors = 0, samples_checked = 0, cyc = 0, drops = 0;
   int br[4] = '{9600, 19200, 57600, 115200};
   // With loop_cable set, terminal-ready comes from our own data-set-ready, as with a looped cable.
   rsmcp_port #(.FIFO_DEPTH(32), .CLK_HZ(HZ)) uut (.clock, .rst_n, .port_enable, .baud_sel, .rxd, .txd,
      .host_dtr(loop_cable ? dev_dsr : host_dtr), .host_rts, .dev_dsr, .dev_cts, .rx_char, .rx_valid,
      .rx_ready, .tx_data, .tx_valid, .tx_ready, .rx_dropped);
   rsmcp_host h (.clock, .txd, .dev_cts, .rxd);
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (rx_dropped === 1'b1) drops++;
      if (cyc > 80000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic stop_test();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic pop(input logic [8:0] exp);
      while (rx_valid !== 1'b1) @(negedge clock);
      chk("rx", rx_char, exp);
      rx_ready = 1'b1;
      @(negedge clock) rx_ready = 1'b0;
      @(negedge clock);
   endtask : pop
   task automatic t_gate();
      chk("dsr off", dev_dsr, 0);
      port_enable = 1'b1;
      @(negedge clock) @(negedge clock);
      chk("dsr on", dev_dsr, 1);
      chk("tx blocked", tx_ready, 0);
      h.send(8'h41, 0);
      repeat (20) @(negedge clock);
      chk("noise", rx_valid, 0);
      host_dtr = 1'b1;
      h.send(8'h0D, 1);
      pop({8'h0D, 1'b1});
      $display("gate test done");
   endtask : t_gate
   task automatic t_loop();
      host_dtr = 1'b0;
      loop_cable = 1'b1;
      @(negedge clock) @(negedge clock);
      h.send(8'h0A, 1);
      pop({8'h0A, 1'b1});
      port_enable = 1'b0;
      @(negedge clock) @(negedge clock);
      chk("loop dsr", dev_dsr, 0);
      chk("loop cts", dev_cts, 0);
      h.send(8'h55, 0);
      repeat (20) @(negedge clock);
      chk("loop noise", rx_valid, 0);
      port_enable = 1'b1;
      loop_cable = 1'b0;
      host_dtr = 1'b1;
      $display("loop test done");
   endtask : t_loop
   task automatic t_rates();
      host_rts = 1'b1;
      for (int b = 0; b < 4; b++) begin
         baud_sel = rsmcp_pkg::rsmcp_baud_e'(b);
         h.bl = HZ / br[b];
         h.send(8'hA5 ^ 8'(b), 1);
         pop({8'hA5 ^ 8'(b), 1'b0});
         tx_data = 8'h3C + 8'(b);
         tx_valid = 1'b1;
         @(posedge clock iff tx_ready === 1'b1);
         @(negedge clock) tx_valid = 1'b0;
         wait (h.got.size() > 0);
         chk("tx", {h.got.pop_front(), 1'b0}, {8'h3C + 8'(b), 1'b0});
      end
      $display("rate test done");
   endtask : t_rates
   task automatic t_fill();
      // The queue plus its output register hold 33 characters, so the last of 34 is lost.
      for (int i = 0; i < 34; i++) h.send(8'(i + 48), i < 28);
      chk("cts full", dev_cts, 0);
      chk("dropped", 9'(drops), 1);
      for (int i = 0; i < 33; i++) pop({8'(i + 48), 1'b0});
      chk("empty", rx_valid, 0);
      $display("fill test done");
   endtask : t_fill
   initial begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      t_gate();
      t_loop();
      t_rates();
      t_fill();
      stop_test();
   end
endmodule : rsmcp_port_tb
